// ---- lpws_params.svh ----
// Constants for the low-power mode wake sequencer
`ifndef LPWS_PARAMS_SVH
`define LPWS_PARAMS_SVH
// ==========================
// Register offsets
`define LPWS_OFS_CTRL_ONE 8'h00
`define LPWS_OFS_CTRL_TWO 8'h01
`define LPWS_OFS_WARM 8'h02
`define LPWS_OFS_STATUS 8'h03
// ==========================
// Field positions
`define LPWS_B_HALT 0
`define LPWS_B_KEYLVL 1
`define LPWS_B_VDEN 2
`define LPWS_B_DOZE 0
`define LPWS_B_MODE_LO 1
`define LPWS_B_MODE_HI 2
// ==========================
// Reset values and timing
`define LPWS_RST_BYTE 8'h00
`define LPWS_RST_WARM 8'hFF
`define LPWS_ZERO_CNT 8'h00
`define LPWS_ONE_CNT 8'h01
`define LPWS_MC_NS 400
`define LPWS_CLK_NS 100
`define LPWS_MC_CLKS 3'((`LPWS_MC_NS + `LPWS_CLK_NS - 1) / `LPWS_CLK_NS)
`define LPWS_ZERO_MC 3'h0
`define LPWS_ONE_MC 3'h1
`endif

// ---- lpws_pkg.sv ----
// Types for the low-power mode wake sequencer
`default_nettype none
package lpws_pkg;
  typedef enum logic [2:0] {
    LPWS_RUN = 3'h0,
    LPWS_HALT = 3'h1,
    LPWS_VDRST = 3'h2,
    LPWS_WARM = 3'h3,
    LPWS_DOZE = 3'h4
  } lpws_state_t;
  typedef enum logic [1:0] {
    LPWS_SINGLE_FAST = 2'h0,
    LPWS_DUAL_FAST = 2'h1,
    LPWS_DUAL_SLOW = 2'h2
  } lpws_mode_t;
  typedef struct packed {
    logic fast_en;
    logic slow_en;
  } lpws_osc_t;
endpackage
`default_nettype wire

// ---- lpws_seq.sv ----
// Deep-halt and doze sequencer with warm-up counter
`include "lpws_params.svh"
`default_nettype none
// How it works
// - Key pin at programmed level ends halt
// - Key level ignored once warm-up started
// - Low supply ends halt, asserts reset
// - Recovery drops reset, warms, single fast
// - Recovery within one machine cycle ignored
// - Restart oscillators of prior run mode
// - Core frozen during warm-up count
// - Resume after halt, clear dividers
// - Single fast mode starts fast oscillator
// - Dual fast mode starts both oscillators
// - Dual slow mode starts slow oscillator
// - Dual fast warm-up uses fast clock
// - Doze stops CPU and watchdog
// - Doze keeps memory, registers, latches
// - Doze holds program counter two ahead
// - Writing doze bit enters doze
// - Pending wake refuses doze entry
// - Watchdog interrupt skips doze entry
// - Writing halt bit enters deep halt
// - Enabled latch ends doze, clears bit
// - Service wake interrupt if master enabled
module lpws_seq (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // Pins
  input wire logic key_wake_pin,
  input wire logic supply_low_pin,
  // Core side
  input wire logic [7:0] irq_latch,
  input wire logic [7:0] per_source_irq_enable,
  input wire logic master_irq_enable,
  input wire logic wdt_irq,
  input wire logic fast_tick,
  input wire logic slow_tick,
  // Outputs
  output lpws_pkg::lpws_osc_t osc,
  output logic core_freeze,
  output logic wdt_stop,
  output logic slow_doze,
  output logic vd_reset,
  output logic resume,
  output logic div_clear,
  output logic irq_service,
  output logic warm_src_fast
);
  // ==========================
  // Pin synchronisers
  logic key_m, key_s, low_m, low_s, low_d;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_m <= 1'b0;
      key_s <= 1'b0;
      low_m <= 1'b0;
      low_s <= 1'b0;
      low_d <= 1'b0;
    end else begin
      key_m <= key_wake_pin;
      key_s <= key_m;
      low_m <= supply_low_pin;
      low_s <= low_m;
      low_d <= low_s;
    end
  end
  logic recovered;
  assign recovered = low_d & ~low_s;
  // ==========================
  // State
  lpws_pkg::lpws_state_t state, next_state;
  lpws_pkg::lpws_mode_t mode, next_mode;
  logic [7:0] ctrl_one, next_ctrl_one;
  logic doze_bit, next_doze_bit;
  logic [7:0] warm_ld, next_warm_ld;
  logic [7:0] warm_cnt, next_warm_cnt;
  logic [2:0] guard, next_guard;
  logic [7:0] rdata_n;
  logic next_resume, next_div_clear, next_irq_service;
  logic wake_pending, wr1, wr2, key_hit, vd_en;
  assign wake_pending = |(irq_latch & per_source_irq_enable);
  assign wr1 = wr_stb && (addr == `LPWS_OFS_CTRL_ONE);
  assign wr2 = wr_stb && (addr == `LPWS_OFS_CTRL_TWO);
  assign vd_en = ctrl_one[`LPWS_B_VDEN];
  assign key_hit = (key_s == ctrl_one[`LPWS_B_KEYLVL]);
  logic tick;
  // Fast clock feeds the divider unless slow run mode
  assign warm_src_fast = (mode != lpws_pkg::LPWS_DUAL_SLOW);
  assign tick = warm_src_fast ? fast_tick : slow_tick;
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_ctrl_one = ctrl_one;
    next_doze_bit = doze_bit;
    next_warm_ld = warm_ld;
    next_warm_cnt = warm_cnt;
    next_guard = (guard != `LPWS_ZERO_MC) ? guard - `LPWS_ONE_MC : guard;
    next_resume = 1'b0;
    next_div_clear = 1'b0;
    next_irq_service = 1'b0;
    if (wr_stb && addr == `LPWS_OFS_WARM) begin
      next_warm_ld = wdata;
    end
    if (wr1) begin
      next_ctrl_one = wdata;
    end
    if (wr2 && state == lpws_pkg::LPWS_RUN) begin
      next_mode = lpws_pkg::lpws_mode_t'(wdata[`LPWS_B_MODE_HI:`LPWS_B_MODE_LO]);
    end
    case (state)
      lpws_pkg::LPWS_RUN: begin
        if (wr1 && wdata[`LPWS_B_HALT]) begin
          next_state = lpws_pkg::LPWS_HALT;
          next_guard = `LPWS_MC_CLKS;
        end else if (wr2 && wdata[`LPWS_B_DOZE]) begin
          // Refusal leaves the bit clear; watchdog is serviced instead
          if (wake_pending || wdt_irq) begin
            next_doze_bit = 1'b0;
            next_irq_service = wdt_irq;
          end else begin
            next_doze_bit = 1'b1;
            next_state = lpws_pkg::LPWS_DOZE;
          end
        end
      end
      lpws_pkg::LPWS_HALT: begin
        if (vd_en && low_s) begin
          next_state = lpws_pkg::LPWS_VDRST;
        end else if (key_hit) begin
          next_state = lpws_pkg::LPWS_WARM;
          next_warm_cnt = warm_ld;
        end else if (recovered && guard == `LPWS_ZERO_MC) begin
          // A recovery edge too close to entry is dropped
          next_state = lpws_pkg::LPWS_WARM;
          next_warm_cnt = warm_ld;
        end
      end
      lpws_pkg::LPWS_VDRST: begin
        next_mode = lpws_pkg::LPWS_SINGLE_FAST;
        if (!low_s) begin
          next_state = lpws_pkg::LPWS_WARM;
          next_warm_cnt = warm_ld;
        end
      end
      lpws_pkg::LPWS_WARM: begin
        // Key level no longer looked at here
        if (warm_cnt == `LPWS_ZERO_CNT) begin
          next_state = lpws_pkg::LPWS_RUN;
          next_ctrl_one[`LPWS_B_HALT] = 1'b0;
          next_resume = 1'b1;
          next_div_clear = 1'b1;
        end else if (tick) begin
          next_warm_cnt = warm_cnt - `LPWS_ONE_CNT;
        end
      end
      lpws_pkg::LPWS_DOZE: begin
        if (wake_pending) begin
          next_state = lpws_pkg::LPWS_RUN;
          next_doze_bit = 1'b0;
          next_resume = 1'b1;
          next_irq_service = master_irq_enable;
        end
      end
      default: next_state = lpws_pkg::LPWS_RUN;
    endcase
    if (state != lpws_pkg::LPWS_RUN && state != lpws_pkg::LPWS_WARM) begin
      next_ctrl_one[`LPWS_B_HALT] = ctrl_one[`LPWS_B_HALT] |
        (state == lpws_pkg::LPWS_HALT || state == lpws_pkg::LPWS_VDRST);
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= lpws_pkg::LPWS_RUN;
      mode <= lpws_pkg::LPWS_SINGLE_FAST;
      ctrl_one <= `LPWS_RST_BYTE;
      doze_bit <= 1'b0;
      warm_ld <= `LPWS_RST_WARM;
      warm_cnt <= `LPWS_ZERO_CNT;
      guard <= `LPWS_ZERO_MC;
      resume <= 1'b0;
      div_clear <= 1'b0;
      irq_service <= 1'b0;
      rdata <= `LPWS_RST_BYTE;
    end else begin
      state <= next_state;
      mode <= next_mode;
      ctrl_one <= next_ctrl_one;
      doze_bit <= next_doze_bit;
      warm_ld <= next_warm_ld;
      warm_cnt <= next_warm_cnt;
      guard <= next_guard;
      resume <= next_resume;
      div_clear <= next_div_clear;
      irq_service <= next_irq_service;
      rdata <= rdata_n;
    end
  end
  // ==========================
  // Read decode
  always_comb begin
    rdata_n = `LPWS_RST_BYTE;
    if (rd_stb) begin
      if (addr == `LPWS_OFS_CTRL_ONE) begin
        rdata_n = ctrl_one;
      end else if (addr == `LPWS_OFS_CTRL_TWO) begin
        rdata_n = {5'h00, mode, doze_bit};
      end else if (addr == `LPWS_OFS_WARM) begin
        rdata_n = warm_ld;
      end else if (addr == `LPWS_OFS_STATUS) begin
        rdata_n = {warm_cnt[7:3], state};
      end
    end
  end
  // ==========================
  // Clock and core control
  logic osc_live;
  assign osc_live = (state != lpws_pkg::LPWS_HALT) && (state != lpws_pkg::LPWS_VDRST);
  // Oscillator set follows the mode register: the mode from before halt, or single fast after detector reset
  assign osc.fast_en = osc_live && (mode != lpws_pkg::LPWS_DUAL_SLOW);
  assign osc.slow_en = osc_live && (mode != lpws_pkg::LPWS_SINGLE_FAST);
  // Freeze holds PC, memory and latches as they stood
  assign core_freeze = (state != lpws_pkg::LPWS_RUN);
  assign wdt_stop = core_freeze;
  assign slow_doze = (state == lpws_pkg::LPWS_DOZE) && (mode == lpws_pkg::LPWS_DUAL_SLOW);
  assign vd_reset = (state == lpws_pkg::LPWS_VDRST);
  // ==========================
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  halt_entry_a: assert property (state == lpws_pkg::LPWS_RUN && wr1 && wdata[`LPWS_B_HALT]
    |=> state == lpws_pkg::LPWS_HALT) else $error("halt not entered");
  key_wake_a: assert property (state == lpws_pkg::LPWS_HALT && !(vd_en && low_s) && key_hit
    |=> state == lpws_pkg::LPWS_WARM) else $error("key did not wake");
  vd_reset_a: assert property (state == lpws_pkg::LPWS_HALT && vd_en && low_s
    |=> vd_reset) else $error("no detector reset");
  vd_mode_a: assert property (state == lpws_pkg::LPWS_VDRST && !low_s
    |=> state == lpws_pkg::LPWS_WARM && mode == lpws_pkg::LPWS_SINGLE_FAST)
    else $error("bad recovery");
  warm_freeze_a: assert property (state == lpws_pkg::LPWS_WARM |-> core_freeze && osc_live)
    else $error("core ran in warm-up");
  warm_end_a: assert property (state == lpws_pkg::LPWS_WARM && warm_cnt == `LPWS_ZERO_CNT
    |=> resume && div_clear ##1 !resume) else $error("bad warm-up end");
  doze_refuse_a: assert property (state == lpws_pkg::LPWS_RUN && wr2 && wdata[`LPWS_B_DOZE]
    && !(wr1 && wdata[`LPWS_B_HALT]) && (wake_pending || wdt_irq)
    |=> !doze_bit && state == lpws_pkg::LPWS_RUN) else $error("doze not refused");
  doze_exit_a: assert property (state == lpws_pkg::LPWS_DOZE && wake_pending
    |=> !doze_bit && resume && irq_service == $past(master_irq_enable))
    else $error("bad doze exit");
  doze_stop_a: assert property (state == lpws_pkg::LPWS_DOZE |-> wdt_stop && core_freeze)
    else $error("cpu ran in doze");
  osc_mode_a: assert property (osc_live && mode == lpws_pkg::LPWS_DUAL_SLOW
    |-> !osc.fast_en && osc.slow_en) else $error("bad oscillator set");
  guard_a: assert property (state == lpws_pkg::LPWS_HALT && guard != `LPWS_ZERO_MC
    && !(vd_en && low_s) && !key_hit |=> state == lpws_pkg::LPWS_HALT)
    else $error("early recovery woke");
  // ==========================
  // Halt and detector checks
  guard_load_a: assert property (
    state == lpws_pkg::LPWS_RUN && wr1 && wdata[`LPWS_B_HALT]
    |=> guard == `LPWS_MC_CLKS)
    else $error("guard not loaded");
  halt_hold_a: assert property (
    state == lpws_pkg::LPWS_HALT && !(vd_en && low_s) && !key_hit && !recovered
    |=> state == lpws_pkg::LPWS_HALT)
    else $error("halt left without cause");
  halt_bit_a: assert property (
    state == lpws_pkg::LPWS_HALT
    |-> ctrl_one[`LPWS_B_HALT])
    else $error("halt bit low in halt");
  halt_osc_a: assert property (
    state == lpws_pkg::LPWS_HALT
    |-> !osc.fast_en && !osc.slow_en)
    else $error("oscillator ran in halt");
  vd_run_a: assert property (
    state == lpws_pkg::LPWS_VDRST
    |-> core_freeze && !osc.fast_en && !osc.slow_en)
    else $error("core ran in detector reset");
  vd_hold_a: assert property (
    state == lpws_pkg::LPWS_VDRST && low_s
    |=> vd_reset)
    else $error("detector reset dropped early");
  vd_rel_a: assert property (
    state == lpws_pkg::LPWS_VDRST && !low_s
    |=> !vd_reset)
    else $error("detector reset held");
  mode_lock_a: assert property (
    (state == lpws_pkg::LPWS_HALT || state == lpws_pkg::LPWS_WARM
    || state == lpws_pkg::LPWS_DOZE) |=> mode == $past(mode))
    else $error("mode changed while stopped");
  // ==========================
  // Warm-up checks
  // Counter must only move on a divided tick
  warm_hold_a: assert property (
    state == lpws_pkg::LPWS_WARM && warm_cnt != `LPWS_ZERO_CNT
    |=> state == lpws_pkg::LPWS_WARM)
    else $error("warm-up cut short");
  warm_load_a: assert property (
    state == lpws_pkg::LPWS_HALT && !(vd_en && low_s) && key_hit
    |=> warm_cnt == $past(warm_ld))
    else $error("warm count not loaded");
  warm_dec_a: assert property (
    state == lpws_pkg::LPWS_WARM && warm_cnt != `LPWS_ZERO_CNT && tick
    |=> warm_cnt == $past(warm_cnt) - `LPWS_ONE_CNT)
    else $error("warm count not decremented");
  warm_still_a: assert property (
    state == lpws_pkg::LPWS_WARM && warm_cnt != `LPWS_ZERO_CNT && !tick
    |=> $stable(warm_cnt))
    else $error("warm count moved without tick");
  halt_clear_a: assert property (
    state == lpws_pkg::LPWS_WARM && warm_cnt == `LPWS_ZERO_CNT
    |=> !ctrl_one[`LPWS_B_HALT])
    else $error("halt bit not cleared");
  warm_single_a: assert property (
    state == lpws_pkg::LPWS_WARM && mode == lpws_pkg::LPWS_SINGLE_FAST
    |-> osc.fast_en && !osc.slow_en)
    else $error("bad single fast oscillators");
  warm_dual_a: assert property (
    state == lpws_pkg::LPWS_WARM && mode == lpws_pkg::LPWS_DUAL_FAST
    |-> osc.fast_en && osc.slow_en)
    else $error("bad dual fast oscillators");
  warm_src_a: assert property (
    mode == lpws_pkg::LPWS_DUAL_FAST
    |-> warm_src_fast)
    else $error("warm-up not on fast clock");
  run_osc_a: assert property (
    state == lpws_pkg::LPWS_RUN && mode == lpws_pkg::LPWS_SINGLE_FAST
    |-> osc.fast_en && !osc.slow_en)
    else $error("slow oscillator ran");
  // ==========================
  // Doze checks
  // Entry and refusal are decided in the write cycle
  doze_enter_a: assert property (
    state == lpws_pkg::LPWS_RUN && wr2 && wdata[`LPWS_B_DOZE] && !wake_pending && !wdt_irq
    |=> state == lpws_pkg::LPWS_DOZE && doze_bit)
    else $error("doze not entered");
  wdt_refuse_a: assert property (
    state == lpws_pkg::LPWS_RUN && wr2 && wdata[`LPWS_B_DOZE] && wdt_irq
    |=> irq_service && !doze_bit)
    else $error("watchdog not serviced");
  doze_stay_a: assert property (
    state == lpws_pkg::LPWS_DOZE && !wake_pending
    |=> state == lpws_pkg::LPWS_DOZE && doze_bit && core_freeze)
    else $error("doze left without wake");
  doze_keep_a: assert property (
    state == lpws_pkg::LPWS_DOZE && !wr1
    |=> $stable(ctrl_one))
    else $error("control changed in doze");
  doze_div_a: assert property (
    state == lpws_pkg::LPWS_DOZE && wake_pending
    |=> !div_clear && state == lpws_pkg::LPWS_RUN)
    else $error("divider cleared on doze exit");
  run_free_a: assert property (
    state == lpws_pkg::LPWS_RUN
    |-> !core_freeze && !wdt_stop)
    else $error("core frozen in run");
  slow_doze_a: assert property (
    state == lpws_pkg::LPWS_DOZE && mode == lpws_pkg::LPWS_DUAL_SLOW
    |-> slow_doze)
    else $error("slow doze not shown");
  wdt_cov_c: cover property (state == lpws_pkg::LPWS_RUN && wr2 && wdt_irq ##1 irq_service);
  guard_cov_c: cover property (state == lpws_pkg::LPWS_HALT && recovered && guard != 3'h0);
  halt_cov_c: cover property (state == lpws_pkg::LPWS_HALT ##[1:50] resume);
  vd_cov_c: cover property (state == lpws_pkg::LPWS_VDRST ##[1:50] resume);
  doze_cov_c: cover property (state == lpws_pkg::LPWS_DOZE ##[1:50] resume);
endmodule // lpws_seq
`default_nettype wire

// ---- lpws_partner.sv ----
// Oscillator and divider model at the far side of the sequencer
`default_nettype none
module lpws_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Oscillator enables
  input wire lpws_pkg::lpws_osc_t osc,
  // Divided ticks
  output logic fast_tick,
  output logic slow_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] slow_div;
  // ==========================
  // Stopped oscillator gives no ticks, so wrong enables stall warm-up
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_tick <= 1'b0;
      slow_div <= 2'h0;
    end else begin
      fast_tick <= osc.fast_en & ~fast_tick;
      slow_div <= (!osc.slow_en || slow_div == 2'h2) ? 2'h0 : slow_div + 2'h1;
    end
  end
  assign slow_tick = osc.slow_en && (slow_div == 2'h2);
endmodule // lpws_partner
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the low-power mode wake sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, irq_latch = 8'h00, irq_en = 8'h00;
  logic wr_stb = 1'b0, rd_stb = 1'b0, key_wake_pin = 1'b0, supply_low_pin = 1'b0;
  logic master_irq_enable = 1'b0, wdt_irq = 1'b0;
  logic fast_tick, slow_tick, core_freeze, wdt_stop, slow_doze, vd_reset;
  logic resume, div_clear, irq_service, warm_src_fast, svc, dc;
  logic [7:0] rdata, d;
  lpws_pkg::lpws_osc_t osc;
  int err_total = 0;
  int checks = 0;
  logic [1:0] exp_osc [3] = '{2'h2, 2'h3, 2'h1};
  always #50 sys_clk = ~sys_clk;
  lpws_seq i_lpws_seq (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .key_wake_pin(key_wake_pin),
    .supply_low_pin(supply_low_pin), .irq_latch(irq_latch), .per_source_irq_enable(irq_en),
    .master_irq_enable(master_irq_enable), .wdt_irq(wdt_irq), .fast_tick(fast_tick),
    .slow_tick(slow_tick), .osc(osc), .core_freeze(core_freeze), .wdt_stop(wdt_stop),
    .slow_doze(slow_doze), .vd_reset(vd_reset), .resume(resume), .div_clear(div_clear),
    .irq_service(irq_service), .warm_src_fast(warm_src_fast));
  lpws_partner i_lpws_partner (.sys_clk(sys_clk), .reset_n(reset_n), .osc(osc),
    .fast_tick(fast_tick), .slow_tick(slow_tick));
  // ==========================
  // Tasks
  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Bounded wait for an exit or service pulse
  task automatic wait_pulse();
    for (int i = 0; i < 300; i++) begin
      step(1);
      if (resume === 1'b1 || irq_service === 1'b1) begin
        svc = irq_service;
        dc = div_clear;
        return;
      end
    end
    err_total++;
    end_of_test();
  endtask
  task automatic wake_key();
    @(posedge sys_clk);
    key_wake_pin <= 1'b1;
  endtask
  // ==========================
  // Scenarios
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    step(1);
    chk("osc_rst", {6'h00, osc}, 8'h02);
    rd(8'h03, d);
    chk("state_rst", d & 8'h07, 8'h00);
    wr(8'h02, 8'h08);
    for (int m = 0; m < 3; m++) begin
      wr(8'h01, 8'(m << 1));
      wr(8'h00, 8'h03);
      step(2);
      chk("freeze", {7'h00, core_freeze}, 8'h01);
      chk("osc_halt", {6'h00, osc}, 8'h00);
      wake_key();
      step(5);
      chk("osc_warm", {6'h00, osc}, {6'h00, exp_osc[m]});
      chk("warm_src", {7'h00, warm_src_fast}, {7'h00, m != 2});
      chk("warm_frz", {7'h00, core_freeze}, 8'h01);
      @(posedge sys_clk);
      key_wake_pin <= 1'b0;
      wait_pulse();
      chk("div_clear", {7'h00, dc}, 8'h01);
      rd(8'h00, d);
      chk("ctrl_one", d, 8'h02);
    end
    // Recovery right after entry must not wake
    supply_low_pin <= 1'b1;
    wr(8'h00, 8'h03);
    supply_low_pin <= 1'b0;
    step(10);
    chk("guard", {7'h00, core_freeze}, 8'h01);
    wake_key();
    wait_pulse();
    @(posedge sys_clk);
    key_wake_pin <= 1'b0;
    // Detector reset from dual slow
    wr(8'h00, 8'h07);
    step(8);
    supply_low_pin <= 1'b1;
    step(4);
    chk("vd_reset", {7'h00, vd_reset}, 8'h01);
    @(posedge sys_clk);
    supply_low_pin <= 1'b0;
    wait_pulse();
    chk("vd_rel", {7'h00, vd_reset}, 8'h00);
    rd(8'h01, d);
    chk("mode_vd", d, 8'h00);
    // Doze with master enable set first, cleared last
    irq_en <= 8'h01;
    wr(8'h01, 8'h01);
    step(2);
    chk("wdt_stop", {7'h00, wdt_stop}, 8'h01);
    rd(8'h01, d);
    chk("doze_bit", d, 8'h01);
    master_irq_enable <= 1'b1;
    irq_latch <= 8'h01;
    wait_pulse();
    chk("svc_on", {7'h00, svc}, 8'h01);
    rd(8'h01, d);
    chk("doze_clr", d, 8'h00);
    wr(8'h01, 8'h01);
    rd(8'h01, d);
    chk("refuse", d, 8'h00);
    chk("no_frz", {7'h00, core_freeze}, 8'h00);
    irq_latch <= 8'h00;
    wdt_irq <= 1'b1;
    wr(8'h01, 8'h01);
    #1;
    svc = irq_service;
    wdt_irq <= 1'b0;
    chk("wdt_svc", {7'h00, svc}, 8'h01);
    rd(8'h01, d);
    chk("wdt_skip", d, 8'h00);
    master_irq_enable <= 1'b0;
    wr(8'h01, 8'h04);
    wr(8'h01, 8'h05);
    step(2);
    chk("slow_doze", {7'h00, slow_doze}, 8'h01);
    @(posedge sys_clk);
    irq_latch <= 8'h01;
    wait_pulse();
    chk("svc_off", {7'h00, svc}, 8'h00);
    rd(8'h01, d);
    chk("mode_back", d, 8'h04);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
